// ===== core/sbd_dma_master.sv
`timescale 1ns/1ps
`include "sbd_params.svh"

module sbd_dma_master import sbd_pkg::*; #(
   parameter int DATA_W = `SBD_DATA_W,
   parameter int BUF_DEPTH = `SBD_BUF_DEPTH
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic mode_burst_i,
   input wire logic mode_80x8x_i,
   input wire logic [`SBD_RETRY_W-1:0] error_retry_count_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic req_write_i,
   input wire logic [`SBD_ADDR_W-1:0] req_addr_i,
   input wire logic [DATA_W-1:0] req_wdata_i,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [DATA_W-1:0] rd_data_o,
   output logic local_dma_stop_o,
   output logic bus_request_out_n_o,
   output logic hold_request_out_o,
   input wire logic bus_grant_n_i,
   output logic bus_owned_indicator_n_o,
   input wire logic host_chip_select_n_i,
   input wire logic bus_release_request_n_i,
   input wire logic bus_error_in_n_i,
   input wire logic transfer_acknowledge_n_i,
   output logic transfer_acknowledge_n_o,
   output logic transfer_acknowledge_oe_o,
   output logic address_strobe_n_o,
   output logic upper_data_strobe_n_o,
   output logic lower_data_strobe_n_o,
   output logic read_not_write_o,
   output logic ctrl_oe_o,
   output logic data_buffer_enable_n_o,
   output logic address_latch_strobe_o,
   output logic extended_address_latch_strobe_o,
   input wire logic [DATA_W-1:0] ad_i,
   output logic [DATA_W-1:0] ad_o,
   output logic ad_oe_o
);
   if (DATA_W != `SBD_DATA_W)
      $error("sbd_dma_master: DATA_W must equal the bus width");
   if (BUF_DEPTH < 2)
      $error("sbd_dma_master: BUF_DEPTH below 2 cannot absorb a stall");

   localparam int UW = $clog2(BUF_DEPTH+1);

   sbd_state_t r_reg, r_next;
   logic ack_s, grant_s, rls_s, berr_s, cs_s;
   logic in_t234, rd_push, buf_in_ready, take, room;
   logic [UW-1:0] buf_used;

   // ===========================================================
   // synchronised pins (second stage only)
   // ===========================================================
   assign ack_s = ~r_reg.s2[`SBD_S_ACK];
   assign grant_s = ~r_reg.s2[`SBD_S_GRANT];
   assign rls_s = ~r_reg.s2[`SBD_S_RLS];
   assign berr_s = ~r_reg.s2[`SBD_S_BERR];
   assign cs_s = ~r_reg.s2[`SBD_S_CS];

   // ===========================================================
   // read data buffer
   // ===========================================================
   // a read is started only when the buffer can take its word, so a
   // stalled consumer holds the bus engine rather than dropping data
   assign rd_push = (r_reg.st == ST_T4) && !r_reg.cur_we && !r_reg.err;
   assign room = (32'(buf_used) + 32'(rd_push)) < BUF_DEPTH;

   sbd_pair_buf #(
      .W(DATA_W),
      .DEPTH(BUF_DEPTH)
   ) u_rd_buf (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_valid_i(rd_push),
      .in_ready_o(buf_in_ready),
      .in_data_i(r_reg.rd_data),
      .out_valid_o(rd_valid_o),
      .out_ready_i(rd_ready_i),
      .out_data_o(rd_data_o),
      .used_o(buf_used)
   );

   // ===========================================================
   // next state
   // ===========================================================
   always_comb begin
      r_next = r_reg;
      take = 1'b0;
      r_next.s1 = {host_chip_select_n_i, bus_error_in_n_i,
                   bus_release_request_n_i, bus_grant_n_i,
                   transfer_acknowledge_n_i};
      r_next.s2 = r_reg.s1;
      r_next.ad_s = ad_i;
      if (req_valid_i && req_ready_o) begin
         r_next.pend_v = 1'b1;
         r_next.pend_we = req_write_i;
         r_next.pend_a = req_addr_i;
         r_next.pend_d = req_wdata_i;
      end
      // release is remembered only while the bus is ours
      if (!r_reg.own_n && rls_s) begin
         r_next.rls = 1'b1;
      end
      case (r_reg.st)
         ST_IDLE: begin
            if (r_reg.halted) begin
               r_next.st = ST_HALT;
            end else if (r_reg.pend_v && r_reg.dio == DIO_IDLE &&
                         !grant_s &&
                         (r_reg.pend_we || buf_in_ready)) begin
               // a grant left over from the last tenure must clear first,
               // or the engine would take the bus without a fresh grant
               r_next.st = ST_ACQ;
               if (mode_80x8x_i) begin
                  r_next.hold = 1'b1;
               end else begin
                  r_next.req_n = 1'b0;
               end
            end
         end
         ST_ACQ: begin
            if (grant_s) begin
               r_next.own_n = 1'b0;
               r_next.st = ST_TX;
               take = 1'b1;
            end
         end
         ST_TX: r_next.st = ST_T1;
         ST_T1: begin
            r_next.st = ST_T2;
            r_next.req_n = 1'b1;
         end
         ST_T2: begin
            if (berr_s) begin
               r_next.err = 1'b1;
            end
            r_next.st = ST_T3;
         end
         ST_T3: begin
            if (berr_s) begin
               r_next.err = 1'b1;
            end
            if (ack_s || berr_s || r_reg.err) begin
               r_next.st = ST_T4;
               r_next.rd_data = r_reg.ad_s;
            end
         end
         ST_T4: begin
            if (r_reg.err) begin
               if (r_reg.retry != '0) begin
                  r_next.retry = r_reg.retry - `SBD_RETRY_W'(1);
                  r_next.err = 1'b0;
                  r_next.st = ST_TX;
               end else begin
                  r_next.halted = 1'b1;
                  r_next.st = ST_I1;
                  r_next.hold = 1'b0;
               end
            end else if (mode_burst_i && r_reg.pend_v && !r_reg.rls &&
                         !rls_s && (r_reg.pend_we || room)) begin
               take = 1'b1;
               if (r_reg.pend_a[`SBD_ADDR_W-1:`SBD_XADDR_LSB] !=
                   r_reg.cur_a[`SBD_ADDR_W-1:`SBD_XADDR_LSB]) begin
                  r_next.st = ST_TX;
               end else begin
                  r_next.st = ST_T1;
               end
            end else begin
               // cycle-steal, release request, nothing queued, or a queued read with no buffer room
               r_next.st = ST_I1;
               r_next.hold = 1'b0;
            end
         end
         ST_I1: begin
            r_next.st = ST_I2;
            r_next.own_n = 1'b1;
            r_next.rls = 1'b0;
         end
         ST_I2: r_next.st = r_reg.halted ? ST_HALT : ST_IDLE;
         ST_HALT: r_next.st = ST_HALT;
         default: r_next.st = ST_IDLE;
      endcase
      if (take) begin
         r_next.pend_v = 1'b0;
         r_next.cur_we = r_reg.pend_we;
         r_next.cur_a = r_reg.pend_a;
         r_next.cur_d = r_reg.pend_d;
         r_next.retry = error_retry_count_i;
      end
      case (r_next.st)
         ST_TX: r_next.ad_out =
            r_next.cur_a[`SBD_ADDR_W-1:`SBD_XADDR_LSB];
         ST_T1: r_next.ad_out = r_next.cur_a[DATA_W-1:0];
         ST_T2: r_next.ad_out = r_next.cur_d;
         default: r_next.ad_out = r_reg.ad_out;
      endcase
      // slave acknowledge for host accesses, only while we are off the bus
      case (r_reg.dio)
         DIO_IDLE: begin
            // never start a slave answer in the cycle the engine leaves idle
            if (cs_s && r_reg.own_n && r_reg.st == ST_IDLE &&
                r_next.st == ST_IDLE) begin
               r_next.dio = DIO_LOW;
            end
         end
         DIO_LOW: begin
            if (!cs_s) begin
               r_next.dio = DIO_HIGH;
            end
         end
         DIO_HIGH: begin
            // float only after the pin is seen high, so it never drifts
            if (!ack_s) begin
               r_next.dio = DIO_IDLE;
            end
         end
         default: r_next.dio = DIO_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         r_reg <= '0;
         r_reg.s1 <= `SBD_SYNC_IDLE;
         r_reg.s2 <= `SBD_SYNC_IDLE;
         r_reg.req_n <= 1'b1;
         r_reg.own_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // ===========================================================
   // pin decode
   // ===========================================================
   assign in_t234 = (r_reg.st == ST_T2) || (r_reg.st == ST_T3) ||
                    (r_reg.st == ST_T4);
   assign req_ready_o = !r_reg.pend_v && !r_reg.halted;
   assign local_dma_stop_o = r_reg.halted;
   assign bus_request_out_n_o = r_reg.req_n;
   assign hold_request_out_o = r_reg.hold;
   assign bus_owned_indicator_n_o = r_reg.own_n;
   assign transfer_acknowledge_n_o = (r_reg.dio == DIO_HIGH);
   assign transfer_acknowledge_oe_o = (r_reg.dio != DIO_IDLE);
   assign address_strobe_n_o = !in_t234;
   assign upper_data_strobe_n_o = !in_t234;
   assign lower_data_strobe_n_o = !in_t234;
   assign read_not_write_o = !r_reg.cur_we;
   assign ctrl_oe_o = !r_reg.own_n && (r_reg.st != ST_I1);
   assign data_buffer_enable_n_o =
      !(in_t234 || (r_reg.cur_we && r_reg.st == ST_T1));
   assign address_latch_strobe_o = (r_reg.st == ST_T1);
   assign extended_address_latch_strobe_o = (r_reg.st == ST_TX);
   assign ad_o = r_reg.ad_out;
   assign ad_oe_o = ctrl_oe_o && ((r_reg.st == ST_TX) ||
                    (r_reg.st == ST_T1) || (r_reg.cur_we && in_t234));

   // ===========================================================
   // assertions
   // ===========================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   breq_drop_a: assert property (
      (r_reg.st == ST_T2) |-> bus_request_out_n_o)
      else $error("bus request still active in T2");
   hold_drop_a: assert property (
      (r_reg.st == ST_T4) ##1 (r_reg.st == ST_I1) |-> !hold_request_out_o)
      else $error("hold request active after last T4");
   cs_ignore_a: assert property (
      !bus_owned_indicator_n_o |-> !transfer_acknowledge_oe_o)
      else $error("host acknowledge driven while bus owned");
   steal_tx_a: assert property (
      (!mode_burst_i && r_reg.st == ST_T1) |-> $past(r_reg.st == ST_TX))
      else $error("cycle-steal transfer without TX state");
   xaddr_out_a: assert property (
      extended_address_latch_strobe_o |-> ad_oe_o && !address_strobe_n_o
      == 1'b0 && ad_o == r_reg.cur_a[`SBD_ADDR_W-1:`SBD_XADDR_LSB])
      else $error("extended address not on bus with its strobe");
   release_a: assert property (
      (r_reg.st == ST_T4 && r_reg.rls && !r_reg.err) |=> (r_reg.st == ST_I1))
      else $error("bus kept after release request");
   err_done_a: assert property (
      (r_reg.st == ST_T3 && r_reg.err) |=> (r_reg.st == ST_T4))
      else $error("errored transfer not completed");
   retry_a: assert property (
      (r_reg.st == ST_T4 && r_reg.err && r_reg.retry != '0)
      |=> (r_reg.st == ST_TX) && extended_address_latch_strobe_o)
      else $error("errored cycle not retried");
   halt_a: assert property (
      (r_reg.st == ST_T4 && r_reg.err && r_reg.retry == '0)
      |=> (r_reg.st == ST_I1) ##1 bus_owned_indicator_n_o ##1
      (local_dma_stop_o && !req_ready_o)[*3])
      else $error("bus not released and halted after error");
   rd_hold_a: assert property (
      rd_push |-> !upper_data_strobe_n_o && !data_buffer_enable_n_o)
      else $error("read strobe dropped before data sampled");
   strobe_neg_a: assert property (
      (r_reg.st == ST_T4) |=> address_strobe_n_o && upper_data_strobe_n_o)
      else $error("strobes not negated after T4");
   float_a: assert property (
      (r_reg.st == ST_I1) |-> !ctrl_oe_o && !ad_oe_o && !r_reg.own_n
      ##1 bus_owned_indicator_n_o)
      else $error("bus not floated in I1 or owned kept in I2");

   read_c: cover property (rd_push ##[1:20] rd_valid_o && rd_ready_i);
   write_c: cover property ((r_reg.st == ST_T4) && r_reg.cur_we);
   retry_c: cover property ((r_reg.st == ST_T4) && r_reg.err
                            ##1 (r_reg.st == ST_TX));
   halt_c: cover property (r_reg.st == ST_HALT);

endmodule // sbd_dma_master

// ===== core/sbd_params.svh
`ifndef SBD_PARAMS_SVH
`define SBD_PARAMS_SVH
// Summary of operation
// - 68xxx mode: bus request drops at the T2 edge of first transfer.
// - 80x8x mode: hold request drops at the edge after last T4.
// - chip select is ignored while the bus is owned.
// - cycle-steal: every transfer starts with the extended-address state.
// - burst: extended-address state on first transfer and on upper-half change.
// - extended latch strobe in TX, address latch strobe in T1.
// - release request is ignored while the bus is not owned.
// - on release request finish the current cycle, then give up the bus.
// - bus error completes the current transfer without waiting for acknowledge.
// - after bus error retry the cycle while the retry count is nonzero.
// - bus error with zero retry: release bus and stop system-side DMA.
// - bus error also stops DMA on the local side.
// - bus error input is ignored outside a DMA bus cycle.
// - address, extended address and length are undefined after a bus error.
// - read strobe stays active until incoming data has been sampled.
// - read: data strobes and address strobe negate when T4 ends.
// - outputs float from I1; owned indicator negates in I2.
// - acknowledge is driven high and seen high before it is floated.

`define SBD_ADDR_W 32
`define SBD_DATA_W 16
`define SBD_RETRY_W 8
`define SBD_XADDR_LSB 16
`define SBD_BUF_DEPTH 2
`define SBD_SYNC_W 5
`define SBD_SYNC_IDLE 5'h1f
`define SBD_S_ACK 0
`define SBD_S_GRANT 1
`define SBD_S_RLS 2
`define SBD_S_BERR 3
`define SBD_S_CS 4

`endif

// ===== core/sbd_pkg.sv
`include "sbd_params.svh"

package sbd_pkg;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ACQ, ST_TX, ST_T1, ST_T2, ST_T3, ST_T4, ST_I1, ST_I2,
      ST_HALT
   } sbd_bus_st_t;

   typedef enum logic [1:0] {DIO_IDLE, DIO_LOW, DIO_HIGH} sbd_dio_st_t;

   typedef struct packed {
      sbd_bus_st_t st;
      sbd_dio_st_t dio;
      logic [`SBD_SYNC_W-1:0] s1;
      logic [`SBD_SYNC_W-1:0] s2;
      logic [`SBD_DATA_W-1:0] ad_s;
      logic req_n;
      logic hold;
      logic own_n;
      logic pend_v;
      logic pend_we;
      logic [`SBD_ADDR_W-1:0] pend_a;
      logic [`SBD_DATA_W-1:0] pend_d;
      logic cur_we;
      logic [`SBD_ADDR_W-1:0] cur_a;
      logic [`SBD_DATA_W-1:0] cur_d;
      logic [`SBD_DATA_W-1:0] ad_out;
      logic [`SBD_DATA_W-1:0] rd_data;
      logic rls;
      logic err;
      logic [`SBD_RETRY_W-1:0] retry;
      logic halted;
   } sbd_state_t;

endpackage

// ===== core/sbd_pair_buf.sv
`timescale 1ns/1ps

module sbd_pair_buf #(
   parameter int W = 16,
   parameter int DEPTH = 2
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o,
   output logic [$clog2(DEPTH+1)-1:0] used_o
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("sbd_pair_buf: DEPTH must be a power of two, at least 2");

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [CW-1:0] cnt;
   } sbd_buf_state_t;

   sbd_buf_state_t r_reg, r_next;
   logic do_wr, do_rd;

   assign in_ready_o = (r_reg.cnt != CW'(DEPTH));
   assign out_valid_o = (r_reg.cnt != '0);
   assign out_data_o = r_reg.mem[r_reg.rp];
   assign used_o = r_reg.cnt;
   assign do_wr = in_valid_i && in_ready_o;
   assign do_rd = out_valid_o && out_ready_i;

   always_comb begin
      r_next = r_reg;
      if (do_wr) begin
         r_next.mem[r_reg.wp] = in_data_i;
         r_next.wp = r_reg.wp + PW'(1);
      end
      if (do_rd) begin
         r_next.rp = r_reg.rp + PW'(1);
      end
      r_next.cnt = r_reg.cnt + CW'(do_wr) - CW'(do_rd);
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

endmodule // sbd_pair_buf

// ===== dv/sbd_host_model.sv
`timescale 1ns/1ps
// ==========================================
// host arbiter and slave memory
module sbd_host_model (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic mode_80x8x_i,
   input wire logic bus_request_out_n_i,
   input wire logic hold_request_out_i,
   input wire logic bus_owned_indicator_n_i,
   input wire logic address_strobe_n_i,
   input wire logic read_not_write_i,
   input wire logic address_latch_strobe_i,
   input wire logic extended_address_latch_strobe_i,
   input wire logic [15:0] ad_i,
   input wire logic slow_i,
   input wire logic fail_load_i,
   input wire logic [3:0] fail_num_i,
   output logic bus_grant_n_o,
   output logic ack_n_o,
   output logic ack_oe_o,
   output logic err_n_o,
   output logic [15:0] ad_o,
   output logic [31:0] wr_addr_o,
   output logic [15:0] wr_data_o
);
   logic [31:0] addr_reg;
   logic [1:0] wait_reg;
   logic [3:0] fail_reg;
   logic [15:0] pat_reg;
   logic as_reg;
   logic ready;
   logic strobe;
   assign strobe = !address_strobe_n_i;
   assign ready = wait_reg == (slow_i ? 2'h3 : 2'h0);
   assign ack_oe_o = strobe;
   // acknowledge held low until the master lifts its strobe
   assign ack_n_o = !(strobe && ready && fail_reg == 4'h0);
   assign err_n_o = !(strobe && ready && fail_reg != 4'h0);
   // released lines toggle so a late sample cannot match by luck
   assign ad_o = (strobe && read_not_write_i) ?
      addr_reg[15:0] ^ addr_reg[31:16] ^ 16'h3c5a : pat_reg;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         bus_grant_n_o <= 1'b1;
         addr_reg <= 32'h0000_0000;
         wait_reg <= 2'h0;
         fail_reg <= 4'h0;
         pat_reg <= 16'h0000;
         as_reg <= 1'b0;
         wr_addr_o <= 32'h0000_0000;
         wr_data_o <= 16'h0000;
      end else begin
         bus_grant_n_o <= !((mode_80x8x_i ? hold_request_out_i :
            !bus_request_out_n_i) || !bus_owned_indicator_n_i);
         if (extended_address_latch_strobe_i) addr_reg[31:16] <= ad_i;
         if (address_latch_strobe_i) addr_reg[15:0] <= ad_i;
         pat_reg <= ~pat_reg;
         as_reg <= strobe;
         if (!strobe) wait_reg <= 2'h0;
         else if (!ready) wait_reg <= wait_reg + 2'h1;
         if (fail_load_i) fail_reg <= fail_num_i;
         else if (as_reg && !strobe && fail_reg != 4'h0)
            fail_reg <= fail_reg - 4'h1;
         if (strobe && !read_not_write_i) begin
            wr_addr_o <= addr_reg;
            wr_data_o <= ad_i;
         end
      end
   end
endmodule // sbd_host_model

// ===== dv/system_bus_dma_master_tb.sv
`timescale 1ns/1ps
module system_bus_dma_master_tb;
   // ==========================================
   // signals
   logic clk_i, reset_i, mode_burst, mode_80, req_valid, req_ready, w;
   logic req_write, rd_valid, rd_ready, stop, req_n, hold, grant_n, own_n;
   logic cs_n, rls_n, err_tb_n, dev_ack_n, dev_ack_oe, as_n, uds_n, lds_n;
   logic rnw, ctrl_oe, dben_n, ale, xal, ad_oe, host_ack_n, host_ack_oe;
   logic host_err_n, slow, fail_load, ack_pin, last_ack, as_prev, own_prev;
   logic [7:0] retry;
   logic [3:0] fail_num;
   logic [31:0] req_addr, wr_addr, a;
   logic [15:0] req_wdata, rd_data, ad_in, ad_out, wr_data, d;
   logic [15:0] exp_q[$];
   int num_errors, cmp_count, xal_cnt, as_cnt, own_cnt, i, j;
   bit stall, ign;
   assign ack_pin = dev_ack_oe ? dev_ack_n : (host_ack_oe ? host_ack_n : 1'b1);
   sbd_dma_master uut (.clk_i(clk_i), .reset_i(reset_i),
      .mode_burst_i(mode_burst), .mode_80x8x_i(mode_80),
      .error_retry_count_i(retry), .req_valid_i(req_valid),
      .req_ready_o(req_ready), .req_write_i(req_write),
      .req_addr_i(req_addr), .req_wdata_i(req_wdata),
      .rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .rd_data_o(rd_data),
      .local_dma_stop_o(stop), .bus_request_out_n_o(req_n),
      .hold_request_out_o(hold), .bus_grant_n_i(grant_n),
      .bus_owned_indicator_n_o(own_n), .host_chip_select_n_i(cs_n),
      .bus_release_request_n_i(rls_n),
      .bus_error_in_n_i(host_err_n & err_tb_n),
      .transfer_acknowledge_n_i(ack_pin),
      .transfer_acknowledge_n_o(dev_ack_n),
      .transfer_acknowledge_oe_o(dev_ack_oe), .address_strobe_n_o(as_n),
      .upper_data_strobe_n_o(uds_n), .lower_data_strobe_n_o(lds_n),
      .read_not_write_o(rnw), .ctrl_oe_o(ctrl_oe),
      .data_buffer_enable_n_o(dben_n), .address_latch_strobe_o(ale),
      .extended_address_latch_strobe_o(xal), .ad_i(ad_in), .ad_o(ad_out),
      .ad_oe_o(ad_oe));
   sbd_host_model host (.clk_i(clk_i), .reset_i(reset_i),
      .mode_80x8x_i(mode_80), .bus_request_out_n_i(req_n),
      .hold_request_out_i(hold), .bus_owned_indicator_n_i(own_n),
      .address_strobe_n_i(as_n), .read_not_write_i(rnw),
      .address_latch_strobe_i(ale), .extended_address_latch_strobe_i(xal),
      .ad_i(ad_out), .slow_i(slow), .fail_load_i(fail_load),
      .fail_num_i(fail_num), .bus_grant_n_o(grant_n), .ack_n_o(host_ack_n),
      .ack_oe_o(host_ack_oe), .err_n_o(host_err_n), .ad_o(ad_in),
      .wr_addr_o(wr_addr), .wr_data_o(wr_data));
   always #5 clk_i = ~clk_i;
   // ==========================================
   // helpers
   function automatic logic [15:0] rd_exp(input logic [31:0] x);
      return x[15:0] ^ x[31:16] ^ 16'h3c5a;
   endfunction
   task complete_run;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [127:0] got, input logic [127:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task tmo(input bit c);
      if (c) begin
         num_errors++;
         complete_run();
      end
   endtask
   task submit(input logic wr, input logic [31:0] ad, input logic [15:0] dt);
      int k;
      @(negedge clk_i);
      for (k = 0; k < 400 && req_ready !== 1'b1; k++) @(negedge clk_i);
      tmo(k == 400);
      req_valid = 1;
      req_write = wr;
      req_addr = ad;
      req_wdata = dt;
      if (!wr) exp_q.push_back(rd_exp(ad));
      @(negedge clk_i);
      req_valid = 0;
   endtask
   task wait_idle;
      int k, n;
      n = 0;
      for (k = 0; k < 3000 && n < 8; k++) begin
         @(negedge clk_i);
         if (req_ready === 1'b1 && own_n === 1'b1 && exp_q.size() == 0) n++;
         else n = 0;
      end
      tmo(n < 8);
   endtask
   task clr;
      xal_cnt = 0;
      as_cnt = 0;
      own_cnt = 0;
   endtask
   // ==========================================
   // monitor and read consumer
   always @(negedge clk_i) begin
      if (!reset_i) begin
         if (xal === 1'b1) xal_cnt++;
         if (as_prev && as_n === 1'b0) as_cnt++;
         if (own_prev && own_n === 1'b0) own_cnt++;
         as_prev = as_n;
         own_prev = own_n;
         if (own_n === 1'b0) chk(dev_ack_oe, 0);
         if (as_n === 1'b0) chk(mode_80 ? hold : req_n, 1);
      end
      rd_ready = !stall && ($urandom % 4 != 0);
      if (rd_ready && rd_valid === 1'b1 && !ign) begin
         tmo(exp_q.size() == 0);
         chk(rd_data, exp_q.pop_front());
      end
   end
   // ==========================================
   // main sequence
   initial begin
      clk_i = 0; reset_i = 1; mode_burst = 0; mode_80 = 0; retry = 8'h00;
      req_valid = 0; req_write = 0; req_addr = 0; req_wdata = 0;
      rd_ready = 0; cs_n = 1; rls_n = 1; err_tb_n = 1; slow = 0;
      fail_load = 0; fail_num = 0; stall = 0; ign = 0;
      as_prev = 1; own_prev = 1; num_errors = 0; cmp_count = 0;
      void'($urandom(38));
      repeat (20) @(posedge clk_i);
      @(negedge clk_i) reset_i = 0;
      chk({req_ready, rd_valid, own_n, req_n, hold, stop}, 6'h2c);
      // single transfers, both bus flavours
      for (int m = 0; m < 2; m++) begin
         mode_80 = m;
         for (int n = 0; n < 10; n++) begin
            clr();
            slow = $urandom % 2;
            a = $urandom;
            d = $urandom;
            w = $urandom % 2;
            submit(w, a, d);
            wait_idle();
            chk({xal_cnt, own_cnt}, {32'h1, 32'h1});
            if (w) chk({wr_addr, wr_data}, {a, d});
            chk({hold, req_n}, 2'b01);
         end
      end
      // burst crossing the low half boundary
      mode_burst = 1; slow = 1; clr();
      a = {16'($urandom), 16'hfffe};
      for (int n = 0; n < 4; n++) submit(1, a + n, 16'h00a0 + n);
      wait_idle();
      chk({xal_cnt, as_cnt, own_cnt}, {32'h2, 32'h4, 32'h1});
      chk({wr_addr, wr_data}, {a + 3, 16'h00a3});
      // release request in mid burst
      clr();
      fork
         for (int n = 0; n < 3; n++) submit(1, a + 9 + n, 16'h0b00 + n);
         begin
            for (i = 0; i < 500 && as_n !== 1'b0; i++) @(negedge clk_i);
            rls_n = 0;
            for (j = 0; j < 500 && own_n !== 1'b1; j++) @(negedge clk_i);
            rls_n = 1;
            tmo(i == 500 || j == 500);
         end
      join
      wait_idle();
      chk(own_cnt > 1, 1);
      chk({wr_addr, wr_data}, {a + 11, 16'h0b02});
      // release request while not owning the bus: a burst must stay whole
      rls_n = 0;
      repeat (10) @(negedge clk_i);
      rls_n = 1; clr();
      for (int n = 0; n < 2; n++) submit(1, a + n, 16'h0c00 + n);
      wait_idle();
      chk({as_cnt, own_cnt}, {32'h2, 32'h1});
      mode_burst = 0;
      // read buffer fills and refuses, then drains
      stall = 1; slow = 0; clr();
      for (int n = 0; n < 3; n++) submit(0, $urandom, 16'h0000);
      repeat (80) @(negedge clk_i);
      chk({as_cnt, rd_valid}, {32'h2, 1'b1});
      stall = 0;
      wait_idle();
      chk(as_cnt, 3);
      // chip select during ownership, then a slave acknowledge
      slow = 1;
      fork
         submit(0, $urandom, 16'h0000);
         begin
            for (i = 0; i < 500 && own_n !== 1'b0; i++) @(negedge clk_i);
            cs_n = 0;
            tmo(i == 500);
         end
      join
      wait_idle();
      for (i = 0; i < 50 && dev_ack_oe !== 1'b1; i++) @(negedge clk_i);
      tmo(i == 50);
      chk({dev_ack_oe, dev_ack_n}, 2'b10);
      cs_n = 1;
      last_ack = 0;
      for (i = 0; i < 50 && dev_ack_oe === 1'b1; i++) begin
         last_ack = dev_ack_n;
         @(negedge clk_i);
      end
      tmo(i == 50);
      chk({dev_ack_oe, last_ack}, 2'b01);
      // bus error with one retry
      retry = 8'h01; clr();
      fail_num = 4'h1;
      fail_load = 1;
      @(negedge clk_i) fail_load = 0;
      submit(0, $urandom, 16'h0000);
      wait_idle();
      chk({as_cnt, stop}, {32'h2, 1'b0});
      // bus error while idle is ignored
      err_tb_n = 0;
      repeat (10) @(negedge clk_i);
      err_tb_n = 1; clr();
      submit(1, $urandom, 16'h0000);
      wait_idle();
      chk({as_cnt, stop}, {32'h1, 1'b0});
      // bus error with no retry halts everything
      retry = 8'h00; ign = 1;
      fail_load = 1;
      @(negedge clk_i) fail_load = 0;
      submit(0, $urandom, 16'h0000);
      for (i = 0; i < 300 && stop !== 1'b1; i++) @(negedge clk_i);
      tmo(i == 300);
      repeat (10) @(negedge clk_i);
      chk({stop, own_n, req_ready}, 3'b110);
      // a second reset brings the engine back
      reset_i = 1;
      repeat (3) @(negedge clk_i);
      reset_i = 0;
      exp_q.delete();
      ign = 0; clr();
      chk(stop, 0);
      submit(0, $urandom, 16'h0000);
      wait_idle();
      chk(as_cnt, 1);
      complete_run();
   end
endmodule // system_bus_dma_master_tb
